// *** core/rtc_irq_pkg.sv ***
// package: register map, field layout and timing for the counter irq block
package rtc_irq_pkg;

  // ==========================================================
  // register offsets (byte offsets on the plain register port)
  localparam logic [7:0] EVT_CTRL_OFS = 8'h04;
  localparam logic [7:0] IRQ_EN_CLR_OFS = 8'h08;
  localparam logic [7:0] IRQ_EN_SET_OFS = 8'h0A;
  localparam logic [7:0] IRQ_FLAG_OFS = 8'h0C;
  localparam logic [7:0] DBG_CTRL_OFS = 8'h0E;
  localparam logic [7:0] SYNC_BUSY_OFS = 8'h10;

  // ==========================================================
  // field positions shared by enable, flag and event-enable registers
  localparam int WRAP_BIT = 15;
  localparam int MATCH_BIT = 8;
  localparam int PER_LSB = 0;
  localparam int PER_NUM = 8;
  localparam int TAP_OFFSET = 2;
  localparam int TAP_WIDTH = 10;
  localparam logic [15:0] IRQ_FIELD_MASK = 16'h81FF;
  localparam int RUN_HALTED_BIT = 0;

  // sync busy bit positions
  localparam int SB_GP1_BIT = 20;
  localparam int SB_GP0_BIT = 19;
  localparam int SB_CNTSYNC_BIT = 15;
  localparam int SB_MATCHVAL_BIT = 5;
  localparam int SB_COUNT_BIT = 3;
  localparam int SB_ENABLE_BIT = 1;
  localparam int SB_SOFTRST_BIT = 0;
  localparam int SB_NUM = 7;

  // tracker slots inside the busy vector
  localparam int SLOT_SOFTRST = 0;
  localparam int SLOT_ENABLE = 1;
  localparam int SLOT_COUNT = 2;
  localparam int SLOT_MATCHVAL = 3;
  localparam int SLOT_CNTSYNC = 4;
  localparam int SLOT_GP0 = 5;
  localparam int SLOT_GP1 = 6;

  // ==========================================================
  // reset values
  localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
  localparam logic [15:0] EVT_EN_RESET = 16'h0000;
  localparam logic [15:0] IRQ_FLAG_RESET = 16'h0000;
  localparam logic DBG_RUN_RESET = 1'b0;
  localparam logic [31:0] SYNC_BUSY_RESET = 32'h0000_0000;
  localparam logic [3:0] PRESC_OFF = 4'h0;

  // ==========================================================
  // timing: crossing time into the counter domain
  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_TIME_NS = 60;
  localparam int SYNC_CYCLES =
    (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CNT_W = 8;

endpackage

// *** core/rtc_sync_busy.sv ***
// module: one synchronization busy tracker with a completion pulse
`timescale 1ns/10ps
module rtc_sync_busy
  import rtc_irq_pkg::*;
#(
  parameter int CYCLES = SYNC_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request and status
  input wire logic start,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [SYNC_CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } rtc_sync_state_t;

  rtc_sync_state_t st_r;
  rtc_sync_state_t st_nxt;

  // ==========================================================
  // busy rises on a request and falls after the crossing time
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = SYNC_CNT_W'(CYCLES - 1);
    end
    else if (st_r.busy)
    begin
      if (st_r.cnt == '0)
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt - 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
  assign done = st_r.done;

endmodule

// *** core/rtc_irq_sync_regs.sv ***
// module: interrupt, event, debug-run and sync-busy logic of the counter
// ==========================================================
// Overview of operation
// - each periodic event fires only while its event output enable is set
// - a one at bit 15 of the clear register drops the wrap enable
// - a one at bit 8 of the clear register drops the match enable
// - ones at bits 7..0 of the clear register drop periodic enables
// - a one at bit 15 of the set register raises the wrap enable
// - a one at bit 8 of the set register raises the match enable
// - ones at bits 7..0 of the set register raise periodic enables
// - set and clear registers share one enable store and read alike
// - wrap flag sets one counter tick after overflow; enabled it requests
// - match flag sets one counter tick after a match; enabled it requests
// - periodic flag n sets on rising prescaler bit n+2; enabled it requests
// - each flag clears by writing one to it; zeros leave it
// - run bit clear halts the counter while debug halts the processor
// - the run bit survives soft reset; a hard reset or a zero write clears it
// - busy bits 20 and 19 stand while general store writes cross
// - busy bit 15 stands while a read-sync enable write crosses
// - busy bit 5 stands while a match value write crosses
// - busy bit 3 stands while a counter read or write crosses
// - busy bit 1 stands while a peripheral enable change crosses
// - busy bit 0 stands while a soft reset request crosses
// - with prescaler off no periodic flags or events appear
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module rtc_irq_sync_regs
  import rtc_irq_pkg::*;
#(
  parameter int SYNC_LEN = SYNC_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  // counter datapath status
  input wire logic cntTick,
  input wire logic wrapHit,
  input wire logic matchHit,
  input wire logic [TAP_WIDTH-1:0] prescTap,
  input wire logic [3:0] prescSel,
  input wire logic dbgHalted,
  // synchronization requests from the rest of the peripheral
  input wire logic [1:0] gpWrReq,
  input wire logic countSyncWrReq,
  input wire logic matchValWrReq,
  input wire logic countRdReq,
  input wire logic countWrReq,
  input wire logic enableWrReq,
  input wire logic softResetReq,
  // interrupt, events and run control
  output logic irqReq,
  output logic wrapEvt,
  output logic matchEvt,
  output logic [PER_NUM-1:0] periodicEvt,
  output logic counterRun,
  output logic softResetDone
);

  // ==========================================================
  // state of the block
  typedef struct packed {
    logic [15:0] irqEn;
    logic [15:0] evEn;
    logic [15:0] flags;
    logic runWhileHalted;
    logic wrapPend;
    logic matchPend;
    logic [PER_NUM-1:0] tapPrev;
    logic tapArmed;
    logic [31:0] rdData;
    logic irq;
    logic wrapEvt;
    logic matchEvt;
    logic [PER_NUM-1:0] perEvt;
    logic run;
    logic srDone;
  } rtc_irq_state_t;

  rtc_irq_state_t st_r;
  rtc_irq_state_t st_nxt;

  logic [SB_NUM-1:0] syncStart;
  logic [SB_NUM-1:0] sync_busy_status;
  logic [SB_NUM-1:0] syncDone;
  logic [31:0] syncWord;

  // ==========================================================
  // helper functions

  // write hit on one register
  function automatic logic wrHit(input logic [7:0] a, input logic [7:0] ofs,
                                 input logic we);
    wrHit = we && (a == ofs);
  endfunction

  // keep only the documented enable and flag positions
  function automatic logic [15:0] fieldOnly(input logic [15:0] v);
    fieldOnly = v & IRQ_FIELD_MASK;
  endfunction

  // ==========================================================
  // sync busy trackers, one per crossing register or bit
  // a repeat request restarts the count, so busy covers the latest one
  always_comb
  begin
    syncStart = '0;
    syncStart[SLOT_SOFTRST] = softResetReq;
    syncStart[SLOT_ENABLE] = enableWrReq;
    syncStart[SLOT_COUNT] = countRdReq | countWrReq;
    syncStart[SLOT_MATCHVAL] = matchValWrReq;
    syncStart[SLOT_CNTSYNC] = countSyncWrReq;
    syncStart[SLOT_GP0] = gpWrReq[0];
    syncStart[SLOT_GP1] = gpWrReq[1];
  end

  // seven identical trackers; slot order is fixed by the package
  genvar gi;
  generate
    for (gi = 0; gi < SB_NUM; gi++)
    begin : g_sync
      rtc_sync_busy #(
        .CYCLES(SYNC_LEN)
      ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .start(syncStart[gi]),
        .busy(sync_busy_status[gi]),
        .done(syncDone[gi])
      );
    end
  endgenerate

  // place tracker bits at their status positions, the rest read zero
  always_comb
  begin
    syncWord = SYNC_BUSY_RESET;
    syncWord[SB_SOFTRST_BIT] = sync_busy_status[SLOT_SOFTRST];
    syncWord[SB_ENABLE_BIT] = sync_busy_status[SLOT_ENABLE];
    syncWord[SB_COUNT_BIT] = sync_busy_status[SLOT_COUNT];
    syncWord[SB_MATCHVAL_BIT] = sync_busy_status[SLOT_MATCHVAL];
    syncWord[SB_CNTSYNC_BIT] = sync_busy_status[SLOT_CNTSYNC];
    syncWord[SB_GP0_BIT] = sync_busy_status[SLOT_GP0];
    syncWord[SB_GP1_BIT] = sync_busy_status[SLOT_GP1];
  end

  // ==========================================================
  // next state
  // ticks and taps arrive already on mclk, so no crossing is needed here
  always_comb
  begin
    logic [15:0] flagSet;
    logic [15:0] flagClr;
    logic [15:0] wv;
    logic [PER_NUM-1:0] tapNow;
    logic [PER_NUM-1:0] tapRise;
    logic presOn;
    logic softRst;
    logic hitEnClr;
    logic hitEnSet;
    logic hitFlag;
    logic hitEvt;
    logic hitDbg;

    st_nxt = st_r;
    flagSet = '0;
    flagClr = '0;
    wv = fieldOnly(wrData[15:0]);
    tapNow = prescTap[TAP_OFFSET +: PER_NUM];
    presOn = (prescSel != PRESC_OFF);
    // the first cycle after reset only loads the tap history
    tapRise = st_r.tapArmed ? (tapNow & ~st_r.tapPrev) : '0;
    softRst = syncDone[SLOT_SOFTRST];
    // one decode per register offset
    hitEnClr = wrHit(addr, IRQ_EN_CLR_OFS, wrEn);
    hitEnSet = wrHit(addr, IRQ_EN_SET_OFS, wrEn);
    hitFlag = wrHit(addr, IRQ_FLAG_OFS, wrEn);
    hitEvt = wrHit(addr, EVT_CTRL_OFS, wrEn);
    hitDbg = wrHit(addr, DBG_CTRL_OFS, wrEn);

    // one-cycle outputs fall back by default
    st_nxt.wrapEvt = 1'b0;
    st_nxt.matchEvt = 1'b0;
    st_nxt.perEvt = '0;
    st_nxt.srDone = softRst;
    st_nxt.tapPrev = tapNow;
    st_nxt.tapArmed = 1'b1;

    // wrap and match are seen on a tick and flagged on the next tick
    if (cntTick)
    begin
      if (st_r.wrapPend)
      begin
        flagSet[WRAP_BIT] = 1'b1;
        st_nxt.wrapEvt = st_r.evEn[WRAP_BIT];
      end
      if (st_r.matchPend)
      begin
        flagSet[MATCH_BIT] = 1'b1;
        st_nxt.matchEvt = st_r.evEn[MATCH_BIT];
      end
      st_nxt.wrapPend = wrapHit;
      st_nxt.matchPend = matchHit;
    end

    // periodic flags and events from rising prescaler taps
    if (presOn)
    begin
      flagSet[PER_LSB +: PER_NUM] = tapRise;
      st_nxt.perEvt = tapRise & st_r.evEn[PER_LSB +: PER_NUM];
    end

    // register writes
    // clear and set sit at different offsets, so they never meet
    if (hitEnClr)
    begin
      st_nxt.irqEn = st_r.irqEn & ~wv;
    end
    if (hitEnSet)
    begin
      st_nxt.irqEn = st_r.irqEn | wv;
    end
    if (hitFlag)
    begin
      flagClr = wv;
    end
    if (hitEvt)
    begin
      st_nxt.evEn = wv;
    end
    if (hitDbg)
    begin
      st_nxt.runWhileHalted = wrData[RUN_HALTED_BIT];
    end
    // the sync busy offset takes no write at all

    // a new event wins over a clear in the same cycle
    // so a flag can never be lost to a late clear
    st_nxt.flags = fieldOnly((st_r.flags & ~flagClr) | flagSet);

    // soft reset completion returns enables, flags, pending and events to reset, keeping the run bit
    // it lands one cycle after busy falls, so a read in that cycle sees busy low with the old state
    if (softRst)
    begin
      st_nxt.irqEn = IRQ_EN_RESET;
      st_nxt.evEn = EVT_EN_RESET;
      st_nxt.flags = IRQ_FLAG_RESET;
      st_nxt.wrapPend = 1'b0;
      st_nxt.matchPend = 1'b0;
      st_nxt.wrapEvt = 1'b0;
      st_nxt.matchEvt = 1'b0;
      st_nxt.perEvt = '0;
      st_nxt.runWhileHalted = st_r.runWhileHalted;
    end

    // interrupt request from enabled flags
    // registered, so it trails the flag by one cycle
    st_nxt.irq = |(st_r.flags & st_r.irqEn);

    // counter halts in debug unless told to run on
    st_nxt.run = ~dbgHalted | st_r.runWhileHalted;

    // read data, present in the cycle after the read strobe only
    // idle cycles and unmapped offsets return zero
    st_nxt.rdData = 32'h0000_0000;
    if (rdEn)
    begin
      case (addr)
        EVT_CTRL_OFS:
        begin
          st_nxt.rdData = {16'h0000, st_r.evEn};
        end
        IRQ_EN_CLR_OFS, IRQ_EN_SET_OFS:
        begin
          st_nxt.rdData = {16'h0000, st_r.irqEn};
        end
        IRQ_FLAG_OFS:
        begin
          st_nxt.rdData = {16'h0000, st_r.flags};
        end
        DBG_CTRL_OFS:
        begin
          st_nxt.rdData = {31'h0000_0000, st_r.runWhileHalted};
        end
        SYNC_BUSY_OFS:
        begin
          st_nxt.rdData = syncWord;
        end
        default:
        begin
          st_nxt.rdData = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // state register; hard reset clears everything including run bit
  // soft reset never reaches this branch; it runs through st_nxt
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r.irqEn <= IRQ_EN_RESET;
      st_r.evEn <= EVT_EN_RESET;
      st_r.flags <= IRQ_FLAG_RESET;
      st_r.runWhileHalted <= DBG_RUN_RESET;
      st_r.wrapPend <= 1'b0;
      st_r.matchPend <= 1'b0;
      st_r.tapPrev <= '0;
      st_r.tapArmed <= 1'b0;
      st_r.rdData <= 32'h0000_0000;
      st_r.irq <= 1'b0;
      st_r.wrapEvt <= 1'b0;
      st_r.matchEvt <= 1'b0;
      st_r.perEvt <= '0;
      st_r.run <= 1'b0;
      st_r.srDone <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  // no logic after the flops, so outputs are glitch free
  assign rdData = st_r.rdData;
  assign irqReq = st_r.irq;
  assign wrapEvt = st_r.wrapEvt;
  assign matchEvt = st_r.matchEvt;
  assign periodicEvt = st_r.perEvt;
  assign counterRun = st_r.run;
  assign softResetDone = st_r.srDone;

endmodule

// *** tb/rtc_irq_sync_regs_properties.sv ***
// checker: port-level properties of the counter irq and sync block
`timescale 1ns/10ps
// ==========
// property checker
module rtc_irq_sync_regs_props
  import rtc_irq_pkg::*;
#(
  parameter int SYNC_LEN = SYNC_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [31:0] rdData,
  // status, requests and outputs
  input wire logic [3:0] prescSel,
  input wire logic dbgHalted,
  input wire logic softResetReq,
  input wire logic [PER_NUM-1:0] periodicEvt,
  input wire logic counterRun,
  input wire logic softResetDone
);
  // request to completion pulse: busy time plus two registers
  localparam int DONE_DLY = SYNC_LEN + 2;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // read data stands only after a read strobe
  property p_rd_idle;
    !rdEn |=> rdData == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero while idle");

  // a set write shows at once through the clear view
  property p_en_set;
    wrEn && addr == IRQ_EN_SET_OFS && wrData[WRAP_BIT]
      ##1 rdEn && addr == IRQ_EN_CLR_OFS |=> rdData[WRAP_BIT];
  endproperty
  a_en_set: assert property (p_en_set)
    else $error("wrap enable not set");

  // a clear write shows at once through the set view
  property p_en_clr;
    wrEn && addr == IRQ_EN_CLR_OFS && wrData[MATCH_BIT]
      ##1 rdEn && addr == IRQ_EN_SET_OFS |=> !rdData[MATCH_BIT];
  endproperty
  a_en_clr: assert property (p_en_clr)
    else $error("match enable not cleared");

  // only the enable fields exist
  property p_en_rsv;
    rdEn && (addr == IRQ_EN_SET_OFS || addr == IRQ_EN_CLR_OFS)
      |=> (rdData & ~32'h0000_81FF) == 32'h0000_0000;
  endproperty
  a_en_rsv: assert property (p_en_rsv)
    else $error("reserved enable bit set");

  // busy word holds only its seven tracker bits
  property p_sb_rsv;
    rdEn && addr == SYNC_BUSY_OFS
      |=> (rdData & ~32'h0018_802B) == 32'h0000_0000;
  endproperty
  a_sb_rsv: assert property (p_sb_rsv)
    else $error("reserved busy bit set");

  // soft reset completes a fixed time after its request
  property p_sw_done;
    softResetReq |-> ##DONE_DLY softResetDone;
  endproperty
  a_sw_done: assert property (p_sw_done)
    else $error("soft reset did not complete");

  // counter may run whenever the processor is not halted
  property p_run;
    !dbgHalted && !$past(rst) |=> counterRun;
  endproperty
  a_run: assert property (p_run)
    else $error("counter stopped without halt");

  // halted with run bit clear stops the counter
  property p_halt;
    rdEn && addr == DBG_CTRL_OFS && dbgHalted
      ##1 dbgHalted && !rdData[RUN_HALTED_BIT] |=> !counterRun;
  endproperty
  a_halt: assert property (p_halt)
    else $error("counter ran while halted");

  // prescaler off gives no periodic events
  property p_pres_off;
    prescSel == PRESC_OFF [*2] |=> periodicEvt == 8'h00;
  endproperty
  a_pres_off: assert property (p_pres_off)
    else $error("periodic event with prescaler off");

  // no periodic event while all event enables are clear
  property p_ev_gate;
    rdEn && addr == EVT_CTRL_OFS ##1 rdData[7:0] == 8'h00
      |-> periodicEvt == 8'h00;
  endproperty
  a_ev_gate: assert property (p_ev_gate)
    else $error("periodic event while disabled");
endmodule

bind rtc_irq_sync_regs rtc_irq_sync_regs_props #(.SYNC_LEN(SYNC_LEN))
  i_props (.mclk, .rst, .addr, .wrData, .wrEn, .rdEn, .rdData,
  .prescSel, .dbgHalted, .softResetReq, .periodicEvt, .counterRun,
  .softResetDone);

// *** tb/rtc_irq_sync_regs_test.sv ***
// testbench: registers, flags, debug run and sync busy of the irq block
`timescale 1ns/10ps
module rtc_irq_sync_regs_test
  import rtc_irq_pkg::*;
;
  logic mclk, rst, wrEn, rdEn, cntTick, wrapHit, matchHit, dbgHalted;
  logic countSyncWrReq, matchValWrReq, countRdReq, countWrReq;
  logic enableWrReq, softResetReq, irqReq, wrapEvt, matchEvt;
  logic counterRun, softResetDone, evClr;
  logic [1:0] gpWrReq, wmSeen;
  logic [7:0] addr, evSeen, req;
  logic [31:0] wrData, rdData, e;
  logic [TAP_WIDTH-1:0] prescTap;
  logic [3:0] prescSel;
  logic [PER_NUM-1:0] periodicEvt;
  int errCount, checksDone, i, k;
  int sbPos[8] = '{0, 1, 3, 3, 5, 15, 19, 20};
  logic [7:0] rOfs[7] = '{8'h04, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h20};
  // write offset, write data, read offset, expected enables
  logic [47:0] enTab[6] = '{48'h0AFF_FF08_81FF, 48'h0800_000A_81FF,
    48'h0880_0008_01FF, 48'h0801_000A_00FF, 48'h0800_AA08_0055,
    48'h0A81_000A_8155};

  // one-cycle request pulses of the sync trackers
  assign {gpWrReq, countSyncWrReq, matchValWrReq, countRdReq, countWrReq,
    enableWrReq, softResetReq} = req;

  rtc_irq_sync_regs #(.SYNC_LEN(2)) i_dut (.mclk, .rst, .addr, .wrData,
    .wrEn, .rdEn, .rdData, .cntTick, .wrapHit, .matchHit, .prescTap,
    .prescSel, .dbgHalted, .gpWrReq, .countSyncWrReq, .matchValWrReq,
    .countRdReq, .countWrReq, .enableWrReq, .softResetReq, .irqReq,
    .wrapEvt, .matchEvt, .periodicEvt, .counterRun, .softResetDone);

  // clock and sticky capture of periodic, wrap and match events
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) evSeen <= evClr ? 8'h00 : evSeen | periodicEvt;
  always @(posedge mclk)
    wmSeen <= evClr ? 2'b00 : wmSeen | {wrapEvt, matchEvt};

  // ==========
  // access tasks
  task chk(logic [31:0] g, logic [31:0] x);
    checksDone++;
    if (g !== x)
    begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge mclk);
    wrEn <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [31:0] x);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge mclk);
    rdEn <= 1'b0;
    #1 chk(rdData, x);
    @(posedge mclk);
  endtask
  task tk(logic w, logic m);
    cntTick <= 1'b1;
    wrapHit <= w;
    matchHit <= m;
    cyc(1);
    cntTick <= 1'b0;
    cyc(3);
  endtask
  task giveVerdict;
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========
  // main sequence
  initial
  begin
    rst = 1'b1;
    evClr = 1'b1;
    {wrEn, rdEn, cntTick, wrapHit, matchHit} = 5'h00;
    req = 8'h00;
    addr = 8'h00;
    wrData = 32'h0000_0000;
    prescTap = 10'h000;
    prescSel = 4'h1;
    dbgHalted = 1'b1;
    cyc(16);
    rst <= 1'b0;
    evClr <= 1'b0;
    cyc(2);
    for (i = 0; i < 7; i++)
      rd(rOfs[i], 32'h0000_0000);
    chk(counterRun, 1'b0);
    for (i = 0; i < 6; i++)
    begin
      wr(enTab[i][47:40], {16'h0000, enTab[i][39:24]});
      rd(enTab[i][23:16], 32'(enTab[i][15:0]));
    end
    // wrap and match events enabled, they fire with their flags
    wr(EVT_CTRL_OFS, 32'h0000_8100);
    // wrap then match flags, zero write then one write
    for (k = 0; k < 2; k++)
    begin
      e = k ? 32'h0000_0100 : 32'h0000_8000;
      tk(k == 0, k == 1);
      tk(1'b0, 1'b0);
      chk(irqReq, 1'b1);
      chk(wmSeen, k ? 2'b11 : 2'b10);
      rd(IRQ_FLAG_OFS, e);
      wr(IRQ_FLAG_OFS, 32'h0000_0000);
      rd(IRQ_FLAG_OFS, e);
      wr(IRQ_FLAG_OFS, e);
      rd(IRQ_FLAG_OFS, 32'h0000_0000);
      chk(irqReq, 1'b0);
    end
    // periodic flags, events enabled on even intervals only
    wr(EVT_CTRL_OFS, 32'h0000_0055);
    for (k = 0; k < PER_NUM; k++)
    begin
      prescTap <= 10'h000;
      evClr <= 1'b1;
      cyc(1);
      prescTap <= 10'(4 << k);
      evClr <= 1'b0;
      cyc(4);
      e = 32'(1 << k);
      chk(irqReq, k % 2 == 0);
      chk(evSeen, k % 2 ? 32'h0000_0000 : e);
      rd(IRQ_FLAG_OFS, e);
      wr(IRQ_FLAG_OFS, 32'h0000_FFFF);
    end
    prescSel <= PRESC_OFF;
    prescTap <= 10'h000;
    evClr <= 1'b1;
    cyc(1);
    prescTap <= 10'h3FC;
    evClr <= 1'b0;
    cyc(4);
    chk(evSeen, 32'h0000_0000);
    rd(IRQ_FLAG_OFS, 32'h0000_0000);
    // run bit, then soft reset keeps it
    wr(DBG_CTRL_OFS, 32'h0000_0001);
    cyc(2);
    chk(counterRun, 1'b1);
    dbgHalted <= 1'b0;
    req <= 8'h01;
    cyc(1);
    req <= 8'h00;
    for (i = 0; i < 20 && softResetDone !== 1'b1; i++)
      @(negedge mclk);
    if (i == 20)
    begin
      errCount++;
    end
    else
    begin
      @(posedge mclk);
      rd(DBG_CTRL_OFS, 32'h0000_0001);
      rd(IRQ_EN_SET_OFS, 32'h0000_0000);
      // busy word is read only, each tracker in turn
      wr(SYNC_BUSY_OFS, 32'hFFFF_FFFF);
      rd(SYNC_BUSY_OFS, 32'h0000_0000);
      for (k = 0; k < 8; k++)
      begin
        req <= 8'(1 << k);
        cyc(1);
        req <= 8'h00;
        rd(SYNC_BUSY_OFS, 32'(1) << sbPos[k]);
        cyc(6);
        rd(SYNC_BUSY_OFS, 32'h0000_0000);
      end
      // a hard reset clears the run bit that soft reset kept
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(2);
      rd(DBG_CTRL_OFS, 32'h0000_0000);
      chk(counterRun, 1'b1);
      dbgHalted <= 1'b1;
      cyc(2);
      chk(counterRun, 1'b0);
    end
    giveVerdict();
  end
endmodule
